// ==== ys_params.svh ====
// Function
// - Channel entries are writable at any time, running or stopped.
// - Nine entry patterns: six single-channel, two two-channel, plus overlap.
// - Two-channel day/month: start from first ON, end from second OFF.
// - Year channel: on Jan 1 of ON year, off after OFF year.
// - Month channel: on first of ON month, off after OFF month.
// - Day channel: on at ON day, off once OFF day elapsed.
// - Day range with month range repeats inside each month of range.
// - Adjacent channel pair forms one continuous on period.
// - Pair with start after end stays on across new year.
// - Pair with years repeats only between first and last year.
// - Pair with blank years repeats every year.
// - Overlap: first ON from any channel switches contact on.
// - Overlap: first OFF from any channel switches off, despite others.
// - Eight independent switches, four channels each, one contact each.
// - Calendar spans years 00 to 99 with two-digit entries.
// - Without power no switching happens; contacts stay open.
`ifndef YS_PARAMS_SVH
`define YS_PARAMS_SVH
`define YS_NUM_SW 8
`define YS_NUM_CH 4
`define YS_SW_STRIDE 8
`define YS_CH_STRIDE 2
`define YS_ADDR_W 7
`define YS_DATA_W 32
`define YS_NUM_ENTRY 64
`define YS_IDX_STATUS 7'h40
`define YS_ENTRY_W 19
`define YS_YEAR_MAX 7'h63
`define YS_YEAR_MIN 7'h00
`endif

// ==== ys_pkg.sv ====
package ys_pkg;
  // One ON or OFF date entry, each field with a valid flag
  typedef struct packed {
    logic yv;
    logic [6:0] yr;
    logic mv;
    logic [3:0] mo;
    logic dv;
    logic [4:0] dy;
  } ys_entry_t;

  // Current date from the calendar, tick pulses at midnight
  typedef struct packed {
    logic tick;
    logic [6:0] yr;
    logic [3:0] mo;
    logic [4:0] dy;
  } ys_date_t;
endpackage : ys_pkg

// ==== ys_year_switch.sv ====
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ys_params.svh"
module ys_year_switch
  import ys_pkg::*;
#(
  parameter int NUM_SW = `YS_NUM_SW
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [`YS_ADDR_W-1:0] reg_addr,
  input wire logic [`YS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`YS_DATA_W-1:0] reg_rdata,
  // Calendar and supply
  input wire ys_date_t cal_date,
  input wire logic power_ok,
  // Contacts to circuit logic
  output logic [NUM_SW-1:0] contact
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic in_rng(input logic [8:0] v, input logic [8:0] lo,
                                  input logic [8:0] hi);
    in_rng = (lo <= hi) ? (v >= lo && v <= hi) : (v >= lo || v <= hi);
  endfunction : in_rng

  function automatic logic yr_in(input logic [6:0] v, input logic [6:0] lo,
                                 input logic [6:0] hi);
    yr_in = (v >= lo) && (v <= hi);
  endfunction : yr_in

  // ----------------------------------------
  // Supply synchroniser
  // ----------------------------------------
  logic pwr_s1_q;
  logic pwr_s2_q;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwr_s1_q <= 1'b0;
      pwr_s2_q <= 1'b0;
    end
    else
    begin
      pwr_s1_q <= power_ok;
      pwr_s2_q <= pwr_s1_q;
    end
  end

  // ----------------------------------------
  // Channel store and register port
  // ----------------------------------------
  ys_entry_t cfg_q [`YS_NUM_ENTRY];
  ys_entry_t cfg_d [`YS_NUM_ENTRY];
  logic [`YS_DATA_W-1:0] rdata_q;
  logic [`YS_DATA_W-1:0] rdata_d;
  logic [NUM_SW-1:0] contact_q;
  logic [NUM_SW-1:0] contact_d;
  logic in_store;

  assign in_store = (reg_addr < `YS_IDX_STATUS);

  // Writes are never gated by run state
  always_comb
  begin
    cfg_d = cfg_q;
    rdata_d = '0;
    if (reg_wr && in_store)
      cfg_d[reg_addr[5:0]] = ys_entry_t'(reg_wdata[`YS_ENTRY_W-1:0]);
    if (reg_rd)
    begin
      if (in_store)
        rdata_d = {{(`YS_DATA_W-`YS_ENTRY_W){1'b0}}, cfg_q[reg_addr[5:0]]};
      else if (reg_addr == `YS_IDX_STATUS)
        rdata_d = {{(`YS_DATA_W-NUM_SW-1){1'b0}}, pwr_s2_q, contact_q};
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < `YS_NUM_ENTRY; i++)
        cfg_q[i] <= '0;
      rdata_q <= '0;
    end
    else
    begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------
  // Channel evaluation
  // ----------------------------------------
  logic [8:0] dm_now;
  logic [NUM_SW-1:0][`YS_NUM_CH-1:0] act;
  logic [NUM_SW-1:0][`YS_NUM_CH-1:0] is_start;

  assign dm_now = {cal_date.mo, cal_date.dy};

  for (genvar s = 0; s < NUM_SW; s++)
  begin : g_sw
    for (genvar c = 0; c < `YS_NUM_CH; c++)
    begin : g_ch
      ys_entry_t on_e;
      ys_entry_t off_e;
      logic d_ok;
      logic m_ok;
      logic y_ok;
      logic single;
      logic pair;
      logic is_end;
      assign on_e = cfg_q[s * `YS_SW_STRIDE + c * `YS_CH_STRIDE];
      assign off_e = cfg_q[s * `YS_SW_STRIDE + c * `YS_CH_STRIDE + 1];
      // Inclusive bounds: off at midnight after the OFF field elapses
      assign d_ok = !on_e.dv ||
                    in_rng({4'h0, cal_date.dy}, {4'h0, on_e.dy}, {4'h0, off_e.dy});
      assign m_ok = !on_e.mv ||
                    in_rng({5'h00, cal_date.mo}, {5'h00, on_e.mo}, {5'h00, off_e.mo});
      assign y_ok = !on_e.yv || yr_in(cal_date.yr, on_e.yr, off_e.yr);
      // Fields combine by AND, so a day range repeats in every month that the month field admits
      assign single = (on_e.dv || on_e.mv || on_e.yv) && d_ok && m_ok && y_ok;
      if (c < `YS_NUM_CH-1)
      begin : g_pair
        ys_entry_t nx_on;
        ys_entry_t nx_off;
        logic [8:0] st;
        logic [8:0] en;
        logic [6:0] fy;
        logic [6:0] ly;
        logic [6:0] py;
        assign nx_on = cfg_q[s * `YS_SW_STRIDE + (c + 1) * `YS_CH_STRIDE];
        assign nx_off = cfg_q[s * `YS_SW_STRIDE + (c + 1) * `YS_CH_STRIDE + 1];
        assign is_start[s][c] = on_e.dv && on_e.mv && !off_e.dv && !off_e.mv &&
                                !nx_on.dv && !nx_on.mv && nx_off.dv && nx_off.mv;
        assign st = {on_e.mo, on_e.dy};
        assign en = {nx_off.mo, nx_off.dy};
        assign fy = on_e.yv ? on_e.yr : `YS_YEAR_MIN;
        assign ly = off_e.yv ? off_e.yr : `YS_YEAR_MAX;
        assign py = cal_date.yr - 7'h01;
        // Wrapped tail belongs to the year in which the period started
        assign pair = (st <= en) ? (dm_now >= st && dm_now <= en && yr_in(cal_date.yr, fy, ly))
                    : ((dm_now >= st && yr_in(cal_date.yr, fy, ly)) ||
                       (dm_now <= en && yr_in(py, fy, ly)));
      end
      else
      begin : g_nopair
        assign is_start[s][c] = 1'b0;
        assign pair = 1'b0;
      end
      if (c > 0)
      begin : g_end
        assign is_end = is_start[s][c-1];
      end
      else
      begin : g_noend
        assign is_end = 1'b0;
      end
      // End channel of a pair gives no result of its own
      assign act[s][c] = is_start[s][c] ? pair : (is_end ? 1'b0 : single);
    end
  end

  // ----------------------------------------
  // Contact update
  // ----------------------------------------
  logic init_q;
  logic init_d;
  logic eval;
  logic [NUM_SW-1:0][`YS_NUM_CH-1:0] prev_q;
  logic [NUM_SW-1:0][`YS_NUM_CH-1:0] prev_d;
  logic [NUM_SW-1:0] on_ev;
  logic [NUM_SW-1:0] off_ev;

  // After reset or supply return the first pass sees no previous state
  assign eval = pwr_s2_q && (cal_date.tick || init_q);

  always_comb
  begin
    init_d = init_q;
    prev_d = prev_q;
    contact_d = contact_q;
    for (int s = 0; s < NUM_SW; s++)
    begin
      on_ev[s] = |(act[s] & ~(init_q ? '0 : prev_q[s]));
      off_ev[s] = |(~act[s] & (init_q ? '0 : prev_q[s]));
    end
    if (!pwr_s2_q)
    begin
      init_d = 1'b1;
      contact_d = '0;
    end
    else if (eval)
    begin
      init_d = 1'b0;
      prev_d = act;
      for (int s = 0; s < NUM_SW; s++)
      begin
        if (off_ev[s])
          contact_d[s] = 1'b0;
        else if (on_ev[s])
          contact_d[s] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      init_q <= 1'b1;
      prev_q <= '0;
      contact_q <= '0;
    end
    else
    begin
      init_q <= init_d;
      prev_q <= prev_d;
      contact_q <= contact_d;
    end
  end

  assign contact = contact_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  chk_power_open: assert property (!pwr_s2_q |=> contact_q == '0)
    else $error("contact closed without supply");
  chk_edit_any: assert property (reg_wr && in_store |=>
      cfg_q[$past(reg_addr[5:0])] == ys_entry_t'($past(reg_wdata[`YS_ENTRY_W-1:0])))
    else $error("channel write lost");
  chk_hold_tick: assert property (pwr_s2_q && !eval |=> $stable(contact_q))
    else $error("contact moved without date advance");
  chk_status_read: assert property (reg_rd && reg_addr == `YS_IDX_STATUS |=>
      reg_rdata[NUM_SW-1:0] == $past(contact_q))
    else $error("status read wrong");
  // ----------------------------------------
  // Check helpers
  // ----------------------------------------
  // Any active channel; a first pass must close exactly these switches
  logic [NUM_SW-1:0] any_act;

  for (genvar s = 0; s < NUM_SW; s++)
  begin : g_any
    assign any_act[s] = |act[s];
  end

  // ----------------------------------------
  // Register port checks
  // ----------------------------------------
  // Read data drops back to zero so a stale word is never taken twice
  chk_rdata_idle: assert property (!reg_rd |=>
      reg_rdata == '0)
    else $error("read data left standing");
  chk_entry_read: assert property (reg_rd && in_store |=>
      reg_rdata[`YS_ENTRY_W-1:0] == $past(cfg_q[reg_addr[5:0]]))
    else $error("entry read wrong");
  chk_status_pwr: assert property (reg_rd && reg_addr == `YS_IDX_STATUS |=>
      reg_rdata[NUM_SW] == $past(pwr_s2_q))
    else $error("supply bit wrong");
  // Addresses past the status word read as zero
  chk_out_read: assert property (reg_rd && reg_addr > `YS_IDX_STATUS |=>
      reg_rdata == '0)
    else $error("unmapped read not zero");

  // ----------------------------------------
  // Supply and evaluation checks
  // ----------------------------------------
  // Supply must pass both flops; a shortcut lets a glitch close contacts
  chk_sync_order: assert property (pwr_s2_q |-> $past(pwr_s1_q))
    else $error("supply skipped a flop");
  chk_supply_init: assert property (!pwr_s2_q |=> init_q)
    else $error("supply return skips first pass");
  // First pass after reset or supply return closes switches with active channels
  chk_init_pass: assert property (init_q && pwr_s2_q |=>
      !init_q && contact_q == $past(any_act))
    else $error("first pass missing");
  chk_eval_done: assert property (eval |=> !init_q)
    else $error("first pass repeated");
  chk_prev_store: assert property (eval |=> prev_q == $past(act))
    else $error("channel state not stored");

  // ----------------------------------------
  // Per-switch contact and channel checks
  // ----------------------------------------
  // Every contact move must trace back to an event or to loss of supply
  for (genvar s = 0; s < NUM_SW; s++)
  begin : g_chk
    chk_off_first: assert property (eval && off_ev[s] |=> !contact_q[s])
      else $error("off event ignored");
    chk_on_first: assert property (eval && on_ev[s] && !off_ev[s] |=> contact_q[s])
      else $error("on event ignored");
    chk_hold_quiet: assert property (eval && !on_ev[s] && !off_ev[s] |=>
        contact_q[s] == $past(contact_q[s]))
      else $error("contact moved without event");
    chk_rise_cause: assert property ($rose(contact_q[s]) |->
        $past(eval && on_ev[s]))
      else $error("contact closed without on event");
    chk_fall_cause: assert property ($fell(contact_q[s]) |->
        $past(!pwr_s2_q || (eval && off_ev[s])))
      else $error("contact opened without cause");
    chk_end_mute: assert property (is_start[s][0] |-> !act[s][1])
      else $error("pair end channel active");
    // Pair entries: start ON at the stride, its OFF next, the end OFF one channel on
    chk_wrap_tail: assert property (is_start[s][0] && !cfg_q[s * `YS_SW_STRIDE].yv &&
        !cfg_q[s * `YS_SW_STRIDE + 1].yv &&
        {cfg_q[s * `YS_SW_STRIDE].mo, cfg_q[s * `YS_SW_STRIDE].dy} >
        {cfg_q[s * `YS_SW_STRIDE + `YS_CH_STRIDE + 1].mo, cfg_q[s * `YS_SW_STRIDE + `YS_CH_STRIDE + 1].dy} &&
        dm_now <= {cfg_q[s * `YS_SW_STRIDE + `YS_CH_STRIDE + 1].mo, cfg_q[s * `YS_SW_STRIDE + `YS_CH_STRIDE + 1].dy}
        |-> act[s][0])
      else $error("wrapped range dropped");
    chk_pair_early: assert property (is_start[s][0] && cfg_q[s * `YS_SW_STRIDE].yv &&
        cal_date.yr < cfg_q[s * `YS_SW_STRIDE].yr |-> !act[s][0])
      else $error("pair active before first year");
    chk_blank_chan: assert property (!is_start[s][0] && !cfg_q[s * `YS_SW_STRIDE].yv &&
        !cfg_q[s * `YS_SW_STRIDE].mv && !cfg_q[s * `YS_SW_STRIDE].dv |-> !act[s][0])
      else $error("blank channel active");
  end

  // ----------------------------------------
  // Scenario covers
  // ----------------------------------------
  cov_pair_on: cover property (is_start[0][0] && act[0][0] && eval);
  cov_overlap_off: cover property (eval && off_ev[0] && (act[0] != '0));
  cov_power_loss: cover property (contact_q[0] ##1 !pwr_s2_q);
  cov_init_close: cover property (init_q && pwr_s2_q && any_act[0]);
  cov_edit_running: cover property (reg_wr && in_store && pwr_s2_q);

endmodule : ys_year_switch

// ==== ys_logic_model.sv ====
`timescale 1ns/1ps
// ------------------
// Circuit logic scan
// ------------------
// Reads every contact once per scan; one cycle late, as a ladder program sees it
module ys_logic_model #(
  parameter int NUM_SW = 8
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Contacts and scanned image
  input wire logic [NUM_SW-1:0] contact,
  output logic [NUM_SW-1:0] seen_q
);
  logic [NUM_SW-1:0] seen_d;
  always_comb seen_d = contact;
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b) seen_q <= '0;
    else seen_q <= seen_d;
  end
endmodule : ys_logic_model

// ==== ys_year_switch_tb.sv ====
`timescale 1ns/1ps
`include "ys_params.svh"
module ys_year_switch_tb
  import ys_pkg::*;
;
  // -------
  // Signals
  // -------
  logic core_clk;
  logic rst_b;
  logic [`YS_ADDR_W-1:0] reg_addr;
  logic [`YS_DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [`YS_DATA_W-1:0] reg_rdata;
  ys_date_t cal_date;
  logic power_ok;
  logic [7:0] contact;
  logic [7:0] seen_q;
  int err_total;
  int checked;
  // Steps {yr, mo, dy, contacts}; jumps are fine, events compare to last eval
  logic [31:0] steps [21] = '{
    32'h0a060347, 32'h0a061307, 32'h0a061407, 32'h0a061907, 32'h0a061a03, 32'h0a061b03,
    32'h0a07094f, 32'h0a07114f, 32'h0a071247, 32'h0a0a1f03, 32'h0a0b0101, 32'h0a0c1f11,
    32'h0b010110, 32'h0b010f14, 32'h0b011004, 32'h0b021c00, 32'h0b030120, 32'h0b041e22,
    32'h0b050102, 32'h0d030100, 32'h0c0302a4};

  ys_year_switch #(.NUM_SW(8)) u_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cal_date(cal_date), .power_ok(power_ok), .contact(contact));
  ys_logic_model #(.NUM_SW(8)) u_logic (.core_clk(core_clk), .rst_b(rst_b),
    .contact(contact), .seen_q(seen_q));

  // -------
  // Helpers
  // -------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function logic [31:0] ent(input logic [23:0] v);
    return {13'h0000, v[22:16] != 7'h00, v[22:16], v[11:8] != 4'h0, v[11:8],
      v[4:0] != 5'h00, v[4:0]};
  endfunction : ent

  task wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [6:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  // Both entries of one channel; blank fields carry a clear valid flag
  task prog(input logic [2:0] s, input logic [1:0] c, input logic [23:0] on,
    input logic [23:0] off);
    wr({1'b0, s, c, 1'b0}, ent(on));
    wr({1'b0, s, c, 1'b1}, ent(off));
  endtask : prog

  // Fixed wait covers tick, contact register and the scan stage
  task tick(input logic [31:0] s);
    @(posedge core_clk);
    cal_date <= {1'b1, s[30:24], s[19:16], s[12:8]};
    @(posedge core_clk);
    cal_date.tick <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : tick

  task set_power(input logic p);
    @(posedge core_clk);
    power_ok <= p;
    repeat (6) @(posedge core_clk);
    #1;
  endtask : set_power

  // ---------
  // Scenarios
  // ---------
  task test_regs;
    prog(3'h0, 2'h0, 24'h020000, 24'h0a0000);
    prog(3'h1, 2'h0, 24'h000400, 24'h000a00);
    prog(3'h2, 2'h0, 24'h000002, 24'h000019);
    prog(3'h3, 2'h0, 24'h000609, 24'h000a11);
    prog(3'h4, 2'h0, 24'h000c1f, 24'h000000);
    prog(3'h4, 2'h1, 24'h000000, 24'h00010f);
    prog(3'h5, 2'h0, 24'h0b0301, 24'h0c0000);
    prog(3'h5, 2'h1, 24'h0b0000, 24'h0c041e);
    prog(3'h6, 2'h2, 24'h000503, 24'h000a1a);
    prog(3'h6, 2'h3, 24'h000602, 24'h000c12);
    prog(3'h7, 2'h0, 24'h320000, 24'h3c0000);
    rd(7'h00, ent(24'h020000));
    rd(7'h20, ent(24'h000c1f));
    wr(7'h41, 32'hffffffff);
    rd(7'h41, 32'h00000000);
    rd(`YS_IDX_STATUS, 32'h00000000);
    chk({24'h000000, seen_q}, 32'h00000000);
  endtask : test_regs

  task test_calendar;
    set_power(1'b1);
    chk({24'h000000, seen_q}, 32'h00000047);
    for (int i = 0; i < 21; i++)
    begin
      // Edited while running; month/year pattern
      if (i == 20) prog(3'h7, 2'h0, 24'h0c0300, 24'h0c0400);
      tick(steps[i]);
      chk({24'h000000, seen_q}, {24'h000000, steps[i][7:0]});
    end
  endtask : test_calendar

  task test_power;
    set_power(1'b0);
    chk({24'h000000, seen_q}, 32'h00000000);
    tick(32'h0b011000);
    chk({24'h000000, seen_q}, 32'h00000000);
    set_power(1'b1);
    chk({24'h000000, seen_q}, 32'h00000004);
    rd(`YS_IDX_STATUS, 32'h00000104);
  endtask : test_power

  task report_and_stop;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // ----------
  // Run
  // ----------
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial
  begin
    #40000;
    err_total++;
    report_and_stop();
  end

  initial
  begin
    rst_b = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cal_date = {1'b0, 7'h0a, 4'h6, 5'h02};
    power_ok = 1'b0;
    err_total = 0;
    checked = 0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    test_regs();
    test_calendar();
    test_power();
    report_and_stop();
  end
endmodule : ys_year_switch_tb
